// ===== core/dtio_regs.sv
// Trigger and front-panel I/O control and status register bank of the digitizer.
// Functional notes
// - Source mask bits 7:0 let channel n raise a local trigger on crossing.
// - Coincidence field sets extra channels needed over threshold; resets to zero.
// - Source mask bit 30 gates external trigger, bit 31 gates software trigger.
// - Output mask bits 7:0 let channel crossings drive the panel trigger output.
// - Output mask bit 30 routes external, bit 31 routes software trigger out.
// - Post-trigger samples equal four times register value plus fixed latency.
// - I/O data read returns line levels; write sets levels of output lines.
// - Config bit 15 clear follows trigger events; set holds bit 14 level.
// - Mode field picks general, programmed or pattern capture of the lines.
// - Bits 5:2 set four-line group direction, only in general purpose mode.
// - Bit 1 puts trigger and clock outputs in high impedance; bit 0 selects TTL.
// - Only channels enabled in the channel mask contribute samples to events.
// - Revision register gives build date, major and minor revision numbers.
// - Stored event count never exceeds the buffer count allowed by size setting.
// - Monitor code of 12 bits drives the converter in voltage level mode.
// - Board information gives memory megabytes per channel and board type.
// - Event size register reports next event length in 32-bit words.
// - Any write to the software trigger location issues one software trigger.
// - While acquisition is stopped no trigger from any source is accepted; the panel trigger output still follows them.
`timescale 1ns/1ps
module dtio_regs #(
  parameter logic [15:0] FW_DATE = 16'h0000,
  parameter logic [7:0] FW_MAJOR = 8'h00,
  parameter logic [7:0] FW_MINOR = 8'h00,
  // Board type code; the value is arbitrary.
  parameter logic [7:0] BOARD_TYPE = 8'h5A,
  parameter logic [7:0] CONST_LATENCY = 8'h00
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [15:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic ACQ_RUN,
  input wire logic [7:0] CHAN_OVER_THR,
  input wire logic EXT_TRIG_IN,
  input wire logic [15:0] LVDS_IN,
  output logic [15:0] LVDS_OUT,
  output logic [15:0] LVDS_OE,
  output logic [15:0] PATTERN_WORD,
  output logic TRIG_ACCEPT,
  output logic PANEL_TRIG_OUT,
  output logic PANEL_TRIG_OE,
  output logic PANEL_CLK_OE,
  output logic PANEL_TTL_SEL,
  output logic [33:0] POST_TRIG_SAMPLES,
  output logic [7:0] CHAN_ENABLE,
  input wire logic [31:0] EVT_STORED,
  input wire logic [31:0] EVT_STORED_MAX,
  input wire logic [31:0] NEXT_EVT_WORDS,
  input wire logic [7:0] MEM_MB_PER_CHAN,
  output logic [11:0] MON_DAC_CODE,
  output logic MON_DAC_APPLY
);
  dtio_trig_if trig ();

  logic [31:0] trig_src_q;
  logic [31:0] trig_out_q;
  logic [31:0] post_trig_q;
  logic [15:0] io_levels_q;
  logic [15:0] io_config_q;
  logic [7:0] chan_en_q;
  logic [11:0] mon_code_q;
  logic [2:0] mon_mode_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic accept_q;
  logic panel_trig_q;
  logic [15:0] pattern_q;
  logic sw_trig_q;
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;
  logic [15:0] lvds_meta_q;
  logic [15:0] lvds_sync_q;

  // Address decode and write strobes.
  wire wr_sw = REG_WR && (REG_ADDR == dtio_pkg::OFS_SW_TRIGGER);
  wire wr_src = REG_WR && (REG_ADDR == dtio_pkg::OFS_TRIG_SRC);
  wire wr_out = REG_WR && (REG_ADDR == dtio_pkg::OFS_TRIG_OUT);
  wire wr_post = REG_WR && (REG_ADDR == dtio_pkg::OFS_POST_TRIG);
  wire wr_lvl = REG_WR && (REG_ADDR == dtio_pkg::OFS_IO_LEVELS);
  wire wr_cfg = REG_WR && (REG_ADDR == dtio_pkg::OFS_IO_CONFIG);
  wire wr_chen = REG_WR && (REG_ADDR == dtio_pkg::OFS_CHAN_EN);
  wire wr_mcode = REG_WR && (REG_ADDR == dtio_pkg::OFS_MON_CODE);
  wire wr_mmode = REG_WR && (REG_ADDR == dtio_pkg::OFS_MON_MODE);

  // Writable fields; reserved bits of the trigger masks are not stored.
  wire [31:0] src_keep = {2'b11, 3'b000, 3'b111, 16'h0000, 8'hFF};
  wire [31:0] out_keep = {2'b11, 22'h000000, 8'hFF};

  // Both triggers are qualified for acceptance by the source mask bits and run state; the panel path uses only the output mask bits.
  wire ext_edge = ext_sync_q && !ext_prev_q;
  wire sw_src = sw_trig_q && trig_src_q[dtio_pkg::BIT_SW_EN];
  wire ext_src = ext_edge && trig_src_q[dtio_pkg::BIT_EXT_EN];
  wire accept_d = ACQ_RUN && (sw_src || ext_src || trig.local_trig);
  wire sw_out = sw_trig_q && trig_out_q[dtio_pkg::BIT_SW_EN];
  wire ext_out = ext_edge && trig_out_q[dtio_pkg::BIT_EXT_EN];
  wire event_out = sw_out || ext_out || trig.out_chan_trig;
  wire panel_trig_d = io_config_q[dtio_pkg::BIT_TEST_MODE] ?
                      io_config_q[dtio_pkg::BIT_TEST_LEVEL] : event_out;

  // Line direction from the mode; groups matter only in general purpose mode.
  wire [1:0] io_mode = io_config_q[dtio_pkg::MODE_LSB +: 2];
  wire [3:0] group_dir = io_config_q[dtio_pkg::DIR_LSB +: 4];
  wire [15:0] group_oe = {{4{group_dir[3]}}, {4{group_dir[2]}},
                          {4{group_dir[1]}}, {4{group_dir[0]}}};
  logic [15:0] lvds_oe_w;
  always_comb begin
    case (io_mode)
      dtio_pkg::DTIO_IO_GENERAL: lvds_oe_w = group_oe;
      dtio_pkg::DTIO_IO_PROGRAMMED: lvds_oe_w = 16'hFFFF;
      dtio_pkg::DTIO_IO_PATTERN: lvds_oe_w = 16'h0000;
      default: lvds_oe_w = 16'h0000;
    endcase
  end
  wire pattern_mode = (io_mode == dtio_pkg::DTIO_IO_PATTERN);

  // Stored count is clamped to the buffer limit as a guard against a stale upstream count.
  wire [31:0] evt_stored_rd = (EVT_STORED > EVT_STORED_MAX) ?
                              EVT_STORED_MAX : EVT_STORED;

  // Read multiplexer; unmapped addresses read as zero.
  logic [31:0] rdata_d;
  always_comb begin
    case (REG_ADDR)
      dtio_pkg::OFS_TRIG_SRC: rdata_d = trig_src_q;
      dtio_pkg::OFS_TRIG_OUT: rdata_d = trig_out_q;
      dtio_pkg::OFS_POST_TRIG: rdata_d = post_trig_q;
      dtio_pkg::OFS_IO_LEVELS: rdata_d = {16'h0000, lvds_sync_q};
      dtio_pkg::OFS_IO_CONFIG: rdata_d = {16'h0000, io_config_q};
      dtio_pkg::OFS_CHAN_EN: rdata_d = {24'h000000, chan_en_q};
      dtio_pkg::OFS_FW_REV: rdata_d = {FW_DATE, FW_MAJOR, FW_MINOR};
      dtio_pkg::OFS_EVT_STORED: rdata_d = evt_stored_rd;
      dtio_pkg::OFS_MON_CODE: rdata_d = {20'h00000, mon_code_q};
      dtio_pkg::OFS_BOARD_INFO: rdata_d = {16'h0000, MEM_MB_PER_CHAN, BOARD_TYPE};
      dtio_pkg::OFS_MON_MODE: rdata_d = {29'h00000000, mon_mode_q};
      dtio_pkg::OFS_EVT_SIZE: rdata_d = NEXT_EVT_WORDS;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Pin synchronisers; logic reads the second stage and, for the trigger edge, the third stage ext_prev_q.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
      lvds_meta_q <= 16'h0000;
      lvds_sync_q <= 16'h0000;
    end else begin
      ext_meta_q <= EXT_TRIG_IN;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      lvds_meta_q <= LVDS_IN;
      lvds_sync_q <= lvds_meta_q;
    end
  end

  // Trigger mask registers.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      trig_src_q <= dtio_pkg::RST_TRIG_SRC;
      trig_out_q <= dtio_pkg::RST_TRIG_OUT;
    end else begin
      if (wr_src) trig_src_q <= REG_WDATA & src_keep;
      if (wr_out) trig_out_q <= REG_WDATA & out_keep;
    end
  end

  // Post-trigger, panel I/O and monitor registers.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      post_trig_q <= dtio_pkg::RST_POST_TRIG;
      io_levels_q <= dtio_pkg::RST_IO_LEVELS;
      io_config_q <= dtio_pkg::RST_IO_CONFIG;
      mon_code_q <= dtio_pkg::RST_MON_CODE;
      mon_mode_q <= dtio_pkg::RST_MON_MODE;
    end else begin
      if (wr_post) post_trig_q <= REG_WDATA;
      if (wr_lvl) io_levels_q <= REG_WDATA[15:0];
      if (wr_cfg) io_config_q <= REG_WDATA[15:0];
      if (wr_mcode) mon_code_q <= REG_WDATA[11:0];
      if (wr_mmode) mon_mode_q <= REG_WDATA[2:0];
    end
  end

  // A mid-run change would split an event's channel layout, so such writes are dropped.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      chan_en_q <= dtio_pkg::RST_CHAN_EN;
    end else if (wr_chen && !ACQ_RUN) begin
      chan_en_q <= REG_WDATA[7:0];
    end
  end

  // Software trigger pulse, trigger outputs and pattern capture.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sw_trig_q <= 1'b0;
      accept_q <= 1'b0;
      panel_trig_q <= 1'b0;
      pattern_q <= 16'h0000;
    end else begin
      sw_trig_q <= wr_sw;
      accept_q <= accept_d;
      panel_trig_q <= panel_trig_d;
      if (accept_d && pattern_mode) pattern_q <= lvds_sync_q;
    end
  end

  // Registered read data, valid one cycle after the read strobe.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= REG_RD;
      if (REG_RD) rdata_q <= rdata_d;
    end
  end

  assign trig.over_thr = CHAN_OVER_THR;
  assign trig.src_mask = trig_src_q[7:0];
  assign trig.out_mask = trig_out_q[7:0];
  // The qualifier assumes software keeps the level below the enabled count.
  assign trig.coinc_level = trig_src_q[dtio_pkg::COINC_LSB +: dtio_pkg::COINC_W];

  dtio_local_trig u_local_trig (
    .clk(CORE_CLK),
    .rst(RST),
    .trig(trig.qual)
  );

  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;
  assign TRIG_ACCEPT = accept_q;
  assign PANEL_TRIG_OUT = panel_trig_q;
  assign PANEL_TRIG_OE = !io_config_q[dtio_pkg::BIT_HIGH_Z];
  assign PANEL_CLK_OE = !io_config_q[dtio_pkg::BIT_HIGH_Z];
  assign PANEL_TTL_SEL = io_config_q[dtio_pkg::BIT_TTL];
  assign LVDS_OUT = io_levels_q & lvds_oe_w;
  assign LVDS_OE = lvds_oe_w;
  assign PATTERN_WORD = pattern_q;
  // Four samples per count plus the trigger pipeline latency.
  assign POST_TRIG_SAMPLES = ({2'b00, post_trig_q} << dtio_pkg::POST_SHIFT) +
                             {26'h0000000, CONST_LATENCY};
  assign CHAN_ENABLE = chan_en_q;
  assign MON_DAC_CODE = mon_code_q;
  assign MON_DAC_APPLY = (mon_mode_q == dtio_pkg::MON_MODE_VLEVEL);
endmodule

// ===== shared/dtio_pkg.sv
// Package with register map, field layout, reset values and build constants.
package dtio_pkg;
  localparam logic [15:0] OFS_SW_TRIGGER = 16'h8108;
  localparam logic [15:0] OFS_TRIG_SRC = 16'h810C;
  localparam logic [15:0] OFS_TRIG_OUT = 16'h8110;
  localparam logic [15:0] OFS_POST_TRIG = 16'h8114;
  localparam logic [15:0] OFS_IO_LEVELS = 16'h8118;
  localparam logic [15:0] OFS_IO_CONFIG = 16'h811C;
  localparam logic [15:0] OFS_CHAN_EN = 16'h8120;
  localparam logic [15:0] OFS_FW_REV = 16'h8124;
  localparam logic [15:0] OFS_EVT_STORED = 16'h812C;
  localparam logic [15:0] OFS_MON_CODE = 16'h8138;
  localparam logic [15:0] OFS_BOARD_INFO = 16'h8140;
  localparam logic [15:0] OFS_MON_MODE = 16'h8144;
  localparam logic [15:0] OFS_EVT_SIZE = 16'h814C;

  localparam int NUM_CHAN = 8;
  localparam int IO_LINES = 16;
  localparam int IO_GROUP = 4;

  // Trigger mask fields; the enable bits are shared by both masks, the coincidence field is in the source mask only.
  localparam int BIT_SW_EN = 31;
  localparam int BIT_EXT_EN = 30;
  localparam int COINC_LSB = 24;
  localparam int COINC_W = 3;

  // I/O configuration fields.
  localparam int BIT_TEST_MODE = 15;
  localparam int BIT_TEST_LEVEL = 14;
  localparam int MODE_LSB = 6;
  localparam int DIR_LSB = 2;
  localparam int BIT_HIGH_Z = 1;
  localparam int BIT_TTL = 0;

  typedef enum logic [1:0] {
    DTIO_IO_GENERAL = 2'h0,
    DTIO_IO_PROGRAMMED = 2'h1,
    DTIO_IO_PATTERN = 2'h2,
    DTIO_IO_UNUSED = 2'h3
  } dtio_io_mode_t;

  // Post-trigger scale: each register count is four samples.
  localparam int POST_SHIFT = 2;

  // Monitor mode code for which the converter code is applied.
  localparam logic [2:0] MON_MODE_VLEVEL = 3'h4;

  localparam logic [31:0] RST_TRIG_SRC = 32'h0000_0000;
  localparam logic [31:0] RST_TRIG_OUT = 32'h0000_0000;
  localparam logic [31:0] RST_POST_TRIG = 32'h0000_0000;
  localparam logic [15:0] RST_IO_LEVELS = 16'h0000;
  localparam logic [15:0] RST_IO_CONFIG = 16'h0000;
  localparam logic [7:0] RST_CHAN_EN = 8'hFF;
  localparam logic [11:0] RST_MON_CODE = 12'h000;
  localparam logic [2:0] RST_MON_MODE = 3'h0;
endpackage

// ===== shared/dtio_trig_if.sv
// Interface between the register bank and the local trigger qualifier.
`timescale 1ns/1ps
interface dtio_trig_if;
  logic [7:0] over_thr;
  logic [7:0] src_mask;
  logic [7:0] out_mask;
  logic [2:0] coinc_level;
  logic local_trig;
  logic out_chan_trig;

  modport regs (
    output over_thr,
    output src_mask,
    output out_mask,
    output coinc_level,
    input local_trig,
    input out_chan_trig
  );

  modport qual (
    input over_thr,
    input src_mask,
    input out_mask,
    input coinc_level,
    output local_trig,
    output out_chan_trig
  );
endinterface

// ===== core/dtio_local_trig.sv
// Channel threshold crossing detection and coincidence qualification.
`timescale 1ns/1ps
module dtio_local_trig (
  input wire logic clk,
  input wire logic rst,
  dtio_trig_if.qual trig
);
  logic [7:0] over_q;
  logic [7:0] rise;
  logic [7:0] enabled_over;
  logic [3:0] over_count;
  logic any_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      over_q <= 8'h00;
    end else begin
      over_q <= trig.over_thr;
    end
  end

  // Only a fresh crossing fires, so a channel sitting above threshold does not retrigger.
  assign rise = trig.over_thr & ~over_q;
  assign enabled_over = trig.over_thr & trig.src_mask;

  always_comb begin
    over_count = 4'h0;
    for (int i = 0; i < dtio_pkg::NUM_CHAN; i++) begin
      over_count = over_count + {3'h0, enabled_over[i]};
    end
  end

  assign any_rise = |(rise & trig.src_mask);
  // The crossing channel counts itself, so the others must reach the level.
  assign trig.local_trig = any_rise && (over_count > {1'b0, trig.coinc_level});
  assign trig.out_chan_trig = |(rise & trig.out_mask);
endmodule

// ===== dv/dtio_host.sv
// Host model that issues single-word accesses on the register strobe port.
`timescale 1ns/1ps
module dtio_host (
  input wire logic clk,
  output logic [15:0] addr,
  output logic wr,
  output logic rd,
  output logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic rvalid
);
  initial begin
    addr = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 32'h00000000;
  end
  // Write data is inverted after the strobe so a stale word never looks valid.
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~d;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [31:0] d, output logic ok);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    d = rdata;
    ok = rvalid;
    rd = 1'b0;
  endtask
endmodule

// ===== dv/dtio_regs_asserts.sv
// Concurrent checks on the ports of the trigger and panel I/O register bank.
`timescale 1ns/1ps
module dtio_regs_asserts #(
  parameter logic [7:0] CONST_LATENCY = 8'h00
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [15:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic ACQ_RUN,
  input wire logic [15:0] LVDS_OUT,
  input wire logic [15:0] LVDS_OE,
  input wire logic TRIG_ACCEPT,
  input wire logic PANEL_TRIG_OUT,
  input wire logic PANEL_TRIG_OE,
  input wire logic PANEL_CLK_OE,
  input wire logic PANEL_TTL_SEL,
  input wire logic [33:0] POST_TRIG_SAMPLES,
  input wire logic [31:0] EVT_STORED_MAX
);
  // Shadows rebuilt from bus traffic, so no internal signal is needed.
  logic [31:0] src_q;
  logic [31:0] out_q;
  logic [15:0] cfg_q;
  logic [15:0] lev_q;
  wire logic [15:0] exp_oe;
  wire logic wr_sw;
  assign wr_sw = REG_WR && REG_ADDR == dtio_pkg::OFS_SW_TRIGGER;
  assign exp_oe = (cfg_q[7:6] == 2'h1) ? 16'hFFFF : (cfg_q[7:6] != 2'h0) ? 16'h0000 :
    {{4{cfg_q[5]}}, {4{cfg_q[4]}}, {4{cfg_q[3]}}, {4{cfg_q[2]}}};
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      src_q <= dtio_pkg::RST_TRIG_SRC;
      out_q <= dtio_pkg::RST_TRIG_OUT;
      cfg_q <= dtio_pkg::RST_IO_CONFIG;
      lev_q <= dtio_pkg::RST_IO_LEVELS;
    end else if (REG_WR) begin
      case (REG_ADDR)
        dtio_pkg::OFS_TRIG_SRC: src_q <= REG_WDATA;
        dtio_pkg::OFS_TRIG_OUT: out_q <= REG_WDATA;
        dtio_pkg::OFS_IO_CONFIG: cfg_q <= REG_WDATA[15:0];
        dtio_pkg::OFS_IO_LEVELS: lev_q <= REG_WDATA[15:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  a_stored_clamp: assert property (
    REG_RD && REG_ADDR == dtio_pkg::OFS_EVT_STORED |=> REG_RVALID && REG_RDATA <= EVT_STORED_MAX)
    else $error("stored count above buffer limit");
  a_post_scale: assert property (
    REG_WR && REG_ADDR == dtio_pkg::OFS_POST_TRIG
    |=> POST_TRIG_SAMPLES == {$past(REG_WDATA), 2'h0} + {26'h0, CONST_LATENCY})
    else $error("post trigger sample count wrong");
  a_panel_drive: assert property (
    PANEL_TRIG_OE == !cfg_q[1] && PANEL_CLK_OE == !cfg_q[1] && PANEL_TTL_SEL == cfg_q[0])
    else $error("panel output enable or standard wrong");
  a_lvds_direction: assert property (LVDS_OE == exp_oe)
    else $error("line direction does not follow mode");
  a_lvds_levels: assert property (LVDS_OUT == (lev_q & LVDS_OE))
    else $error("driven line levels wrong");
  a_sw_accept: assert property (
    (wr_sw && src_q[31] && ACQ_RUN) ##1 ACQ_RUN |-> ##[0:2] TRIG_ACCEPT)
    else $error("software trigger not accepted");
  a_sw_masked: assert property (
    wr_sw && src_q == 32'h0 |=> !TRIG_ACCEPT [*3])
    else $error("masked software trigger accepted");
  a_stop_quiet: assert property (!ACQ_RUN [*4] |-> !TRIG_ACCEPT)
    else $error("trigger accepted while stopped");
  a_test_level: assert property (
    (cfg_q[15] && $stable(cfg_q[14])) [*3] |-> PANEL_TRIG_OUT == cfg_q[14])
    else $error("test level not on panel trigger");
  a_sw_panel: assert property (
    wr_sw && out_q[31] && !cfg_q[15] |-> ##[1:3] PANEL_TRIG_OUT)
    else $error("software trigger missing on panel");
endmodule
bind dtio_regs dtio_regs_asserts #(.CONST_LATENCY(CONST_LATENCY)) chk_u (
  .CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .ACQ_RUN(ACQ_RUN),
  .LVDS_OUT(LVDS_OUT), .LVDS_OE(LVDS_OE), .TRIG_ACCEPT(TRIG_ACCEPT),
  .PANEL_TRIG_OUT(PANEL_TRIG_OUT), .PANEL_TRIG_OE(PANEL_TRIG_OE), .PANEL_CLK_OE(PANEL_CLK_OE),
  .PANEL_TTL_SEL(PANEL_TTL_SEL), .POST_TRIG_SAMPLES(POST_TRIG_SAMPLES),
  .EVT_STORED_MAX(EVT_STORED_MAX));

// ===== dv/tb.sv
// Self-checking testbench for the trigger and panel I/O register bank.
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] fw_date = 16'h2A17;
  localparam logic [7:0] fw_maj = 8'h03;
  localparam logic [7:0] fw_min = 8'h07;
  // Board type code; the value is arbitrary.
  localparam logic [7:0] btype = 8'h5A;
  localparam logic [7:0] lat = 8'h0B;
  localparam logic [7:0] mb = 8'h02;
  localparam logic [31:0] nxt = 32'h00000123;
  localparam logic [31:0] evmax = 32'h00000004;
  localparam logic [15:0] rsa [14] = '{dtio_pkg::OFS_SW_TRIGGER, dtio_pkg::OFS_TRIG_SRC,
    dtio_pkg::OFS_TRIG_OUT, dtio_pkg::OFS_POST_TRIG, dtio_pkg::OFS_IO_LEVELS,
    dtio_pkg::OFS_IO_CONFIG, dtio_pkg::OFS_CHAN_EN, dtio_pkg::OFS_FW_REV,
    dtio_pkg::OFS_EVT_STORED, dtio_pkg::OFS_MON_CODE, dtio_pkg::OFS_BOARD_INFO,
    dtio_pkg::OFS_MON_MODE, dtio_pkg::OFS_EVT_SIZE, 16'h8200};
  localparam logic [31:0] rsv [14] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000A5C3, 32'h0,
    32'h000000FF, {fw_date, fw_maj, fw_min}, evmax, 32'h0, {16'h0, mb, btype}, 32'h0, nxt, 32'h0};
  localparam logic [31:0] rwm [7] = '{32'hC70000FF, 32'hC00000FF, 32'hFFFFFFFF,
    32'h0000FFFF, 32'h000000FF, 32'h00000FFF, 32'h00000007};
  // Register slots written by the access test, in the order of the writable masks above.
  localparam int wi [7] = '{1, 2, 3, 5, 6, 9, 11};
  localparam logic [15:0] cfg [5] = '{16'hC000, 16'h8000, 16'h0014, 16'h0040, 16'h0083};
  localparam logic [15:0] cfg_oe [5] = '{16'h0000, 16'h0000, 16'h0F0F, 16'hFFFF, 16'h0000};
  localparam logic [3:0] cfg_pm [5] = '{4'hE, 4'h6, 4'h6, 4'h6, 4'h1};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic acq = 1'b0;
  logic ext = 1'b0;
  logic [7:0] thr = 8'h00;
  logic [15:0] far = 16'hA5C3;
  logic [31:0] seed = 32'h00000019;
  logic [15:0] a;
  logic w, r, rv, acc, pto, ptoe, pcoe, ttl, app, ok;
  logic [31:0] wd, rdata, rdat, m;
  logic [31:0] pv = dtio_pkg::RST_POST_TRIG;
  logic [15:0] lout, loe, pat;
  wire logic [15:0] pin;
  logic [33:0] pts, na, np;
  logic [7:0] chen, mk, pre, pst;
  logic [11:0] dac;
  logic [2:0] co;
  int n, k, mismatches = 0, checks = 0;
  always #50 clk = ~clk;
  // Undriven lines show the far-side pattern, so a stale driven level is visible.
  assign pin = (lout & loe) | (far & ~loe);
  dtio_regs #(.FW_DATE(fw_date), .FW_MAJOR(fw_maj), .FW_MINOR(fw_min), .BOARD_TYPE(btype),
    .CONST_LATENCY(lat)) dut_u (
    .CORE_CLK(clk), .RST(rst), .REG_ADDR(a), .REG_WR(w), .REG_RD(r), .REG_WDATA(wd),
    .REG_RDATA(rdata), .REG_RVALID(rv), .ACQ_RUN(acq), .CHAN_OVER_THR(thr), .EXT_TRIG_IN(ext),
    .LVDS_IN(pin), .LVDS_OUT(lout), .LVDS_OE(loe), .PATTERN_WORD(pat), .TRIG_ACCEPT(acc),
    .PANEL_TRIG_OUT(pto), .PANEL_TRIG_OE(ptoe), .PANEL_CLK_OE(pcoe), .PANEL_TTL_SEL(ttl),
    .POST_TRIG_SAMPLES(pts), .CHAN_ENABLE(chen), .EVT_STORED(32'h00000009),
    .EVT_STORED_MAX(evmax), .NEXT_EVT_WORDS(nxt), .MEM_MB_PER_CHAN(mb), .MON_DAC_CODE(dac),
    .MON_DAC_APPLY(app));
  dtio_host host_u (.clk(clk), .addr(a), .wr(w), .rd(r), .wdata(wd), .rdata(rdata), .rvalid(rv));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_local(input logic [7:0] mk, input logic [2:0] co,
      input logic [7:0] pre, input logic [7:0] pst);
    return ((pst & ~pre & mk) != 8'h0) && ($countones(pst & mk) > co);
  endfunction
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [15:0] adr, input logic [31:0] exp);
    host_u.rd_reg(adr, rdat, ok);
    check("read valid", {33'h0, ok}, 34'h1);
    check("read data", {2'h0, rdat}, {2'h0, exp});
  endtask
  task automatic count(output logic [33:0] na, output logic [33:0] np);
    na = 34'h0;
    np = 34'h0;
    repeat (8) begin
      @(posedge clk);
      #1;
      na += {33'h0, acc === 1'b1};
      np += {33'h0, pto === 1'b1};
    end
  endtask
  task automatic fire(input logic sw, output logic [33:0] na, output logic [33:0] np);
    if (sw) begin
      host_u.wr_reg(dtio_pkg::OFS_SW_TRIGGER, seed);
    end else begin
      @(negedge clk);
      ext = 1'b1;
      repeat (2) @(negedge clk);
      ext = 1'b0;
    end
    count(na, np);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    host_u.wr_reg(dtio_pkg::OFS_FW_REV, 32'hFFFFFFFF);
    host_u.wr_reg(16'h8200, 32'hFFFFFFFF);
    for (n = 0; n < 14; n++) begin
      rd_chk(rsa[n], rsv[n]);
    end
    $display("test reset_values done");
    // Acquisition stays stopped here, so channel mask writes are legal.
    for (n = 0; n < 24; n++) begin
      k = n % 7;
      seed = lfsr(seed);
      host_u.wr_reg(rsa[wi[k]], seed);
      rd_chk(rsa[wi[k]], seed & rwm[k]);
      if (k == 2) pv = seed;
      check("post samples", pts, {pv, 2'h0} + {26'h0, lat});
    end
    host_u.wr_reg(dtio_pkg::OFS_MON_MODE, {29'h0, dtio_pkg::MON_MODE_VLEVEL});
    check("monitor apply", {33'h0, app}, 34'h1);
    host_u.wr_reg(dtio_pkg::OFS_CHAN_EN, 32'h0000003C);
    host_u.wr_reg(dtio_pkg::OFS_MON_CODE, 32'hFFFFF5A6);
    check("channel enables", {26'h0, chen}, 34'h3C);
    check("monitor code", {22'h0, dac}, 34'h5A6);
    acq = 1'b1;
    host_u.wr_reg(dtio_pkg::OFS_CHAN_EN, 32'h000000C3);
    acq = 1'b0;
    check("enables held in run", {26'h0, chen}, 34'h3C);
    host_u.wr_reg(dtio_pkg::OFS_IO_CONFIG, 32'h0);
    $display("test register_access done");
    for (n = 0; n < 5; n++) begin
      m = (n == 4) ? 32'hC0000000 : {n[1:0], 30'h0};
      @(negedge clk);
      acq = (n != 4);
      host_u.wr_reg(dtio_pkg::OFS_TRIG_SRC, m);
      host_u.wr_reg(dtio_pkg::OFS_TRIG_OUT, m);
      fire(1'b1, na, np);
      check("sw accepts", na, {33'h0, m[31] & acq});
      check("sw panel", np, {33'h0, m[31]});
      fire(1'b0, na, np);
      check("ext accepts", na, {33'h0, m[30] & acq});
      check("ext panel", np, {33'h0, m[30]});
    end
    $display("test trigger_sources done");
    host_u.wr_reg(dtio_pkg::OFS_TRIG_OUT, 32'h0);
    acq = 1'b1;
    for (n = 0; n < 26; n++) begin
      seed = lfsr(seed);
      mk = (n < 2) ? 8'hFF : seed[7:0] | 8'h01;
      co = (n < 2) ? 3'h1 : 3'(seed[10:8] % $countones(mk));
      pre = (n == 1) ? 8'h02 : 8'h00;
      pst = (n == 0) ? 8'h01 : (n == 1) ? 8'h03 : seed[23:16];
      @(negedge clk);
      thr = pre;
      host_u.wr_reg(dtio_pkg::OFS_TRIG_SRC, {seed[31:27], co, seed[23:8], mk});
      rd_chk(dtio_pkg::OFS_TRIG_SRC, {seed[31:30], 3'h0, co, 16'h0, mk});
      thr = pst;
      count(na, np);
      check("local accepts", na, {33'h0, exp_local(mk, co, pre, pst)});
    end
    @(negedge clk);
    thr = 8'h00;
    $display("test local_trigger done");
    for (n = 0; n < 5; n++) begin
      seed = lfsr(seed);
      host_u.wr_reg(dtio_pkg::OFS_IO_CONFIG, {16'h0, cfg[n]});
      host_u.wr_reg(dtio_pkg::OFS_IO_LEVELS, seed);
      repeat (3) @(negedge clk);
      check("line enables", {18'h0, loe}, {18'h0, cfg_oe[n]});
      check("line levels", {18'h0, lout}, {18'h0, seed[15:0] & cfg_oe[n]});
      check("panel pins", {30'h0, pto, ptoe, pcoe, ttl}, {30'h0, cfg_pm[n]});
      m = {16'h0, (seed[15:0] & cfg_oe[n]) | (far & ~cfg_oe[n])};
      rd_chk(dtio_pkg::OFS_IO_LEVELS, m);
    end
    far = seed[31:16];
    host_u.wr_reg(dtio_pkg::OFS_TRIG_SRC, 32'h80000000);
    fire(1'b1, na, np);
    check("pattern word", {18'h0, pat}, {18'h0, far});
    $display("test panel_io done");
    final_report;
  end
endmodule
